// File: common/dma_pkg.sv
// Shared constants and types of the four-channel DMA active-cycle block.
`default_nettype none
package dma_pkg;
  localparam int NCH   = 4;
  localparam int PIN_W = 21;
  // Register codes on the four low address lines.
  localparam logic [3:0] REG_CMD_STAT  = 4'h8;
  localparam logic [3:0] REG_REQ       = 4'h9;
  localparam logic [3:0] REG_MASK_BIT  = 4'hA;
  localparam logic [3:0] REG_MODE      = 4'hB;
  localparam logic [3:0] REG_CLR_FF    = 4'hC;
  localparam logic [3:0] REG_MCLR_TEMP = 4'hD;
  localparam logic [3:0] REG_CLR_MASK  = 4'hE;
  localparam logic [3:0] REG_MASK_ALL  = 4'hF;
  // Command register bit positions.
  localparam int CMD_M2M      = 0;
  localparam int CMD_HOLD0    = 1;
  localparam int CMD_DISABLE  = 2;
  localparam int CMD_COMPRESS = 3;
  localparam int CMD_ROTATE   = 4;
  localparam int CMD_ACK_HIGH = 7;
  // Data field positions of request, mask and mode writes, and the address bit that selects channel registers.
  localparam int SEL_MSB  = 1;
  localparam int SET_BIT  = 2;
  localparam int MODE_LSB = 2;
  localparam int CHAN_IDX = 3;
  // Reset values and arithmetic constants.
  localparam logic [7:0]  CMD_RESET    = 8'h00;
  localparam logic [3:0]  MASK_RESET   = 4'hF;
  localparam logic [3:0]  M2M_REQ_MASK = 4'hD;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_WRAP   = 16'hFFFF;
  localparam logic [15:0] ADDR_STEP    = 16'h0001;
  localparam logic [PIN_W-1:0] PIN_RESET = 21'h1C0001;

  typedef enum logic [1:0] {
    XM_DEMAND  = 2'h0,
    XM_SINGLE  = 2'h1,
    XM_BLOCK   = 2'h2,
    XM_CASCADE = 2'h3
  } xfer_mode_type;

  typedef enum logic [1:0] {
    XT_VERIFY = 2'h0,
    XT_WRITE  = 2'h1,
    XT_READ   = 2'h2,
    XT_NONE   = 2'h3
  } xfer_kind_type;

  // Six stored mode bits, as written in data bits 7..2.
  typedef struct packed {
    xfer_mode_type mode;
    logic          dec;
    logic          autoinit;
    xfer_kind_type kind;
  } mode_type;

  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
  } strobe_type;

  typedef enum logic [2:0] {
    ST_IDLE        = 3'h0,
    ST_WAIT_HOLD   = 3'h1,
    ST_ADDR_UPDATE = 3'h3,
    ST_ADDR_CHANGE = 3'h2,
    ST_READ_EXTEND = 3'h6,
    ST_STROBE      = 3'h7,
    ST_CASCADE     = 3'h5
  } state_type;
endpackage : dma_pkg
`default_nettype wire

// File: rtl/dma_pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/10ps
`default_nettype none
module dma_pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] pins_in,
  output logic      [WIDTH-1:0] pins_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= RESET_VAL;
      pins_out <= RESET_VAL;
    end else if (ce_in) begin
      meta_reg <= pins_in;
      pins_out <= meta_reg;
    end
  end
endmodule : dma_pin_sync
`default_nettype wire

// File: rtl/dma_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module dma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic             clear_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_ready_in & out_valid_out;

  always_ff @(posedge clk_sys_in) begin
    if (ce_in && push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce_in) begin
      if (clear_in) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg  <= '0;
      end else begin
        if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
        if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
        count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule : dma_fifo
`default_nettype wire

// File: rtl/dma_active.sv
// Active-cycle logic and program port of a four-channel DMA controller.
`timescale 1ns/10ps
`default_nettype none
module dma_active
  import dma_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock, reset and clock enable
  input  wire logic           clk_sys_in,
  input  wire logic           nrst_in,
  input  wire logic           ce_in,
  // Program port
  input  wire logic           cs_n_in,
  input  wire logic           io_read_n_in,
  input  wire logic           io_write_n_in,
  input  wire logic [3:0]     lower_addr_byte_in,
  input  wire logic [7:0]     data_in,
  output logic      [7:0]     data_out,
  output logic                data_oe_n_out,
  // Hold handshake
  output logic                hold_req_out,
  input  wire logic           hold_ack_in,
  // Channel handshakes
  input  wire logic [NCH-1:0] chan_req_in,
  output logic      [NCH-1:0] chan_ack_out,
  // End of process pin
  input  wire logic           end_of_process_n_in,
  output logic                end_of_process_n_out,
  output logic                end_of_process_oe_n_out,
  // Address outputs
  output logic      [7:0]     lower_addr_byte_out,
  output logic                addr_oe_n_out,
  output logic                upper_addr_strobe_out,
  output logic                upper_addr_enable_out,
  // Memory and I/O strobes
  output logic                mem_read_n_out,
  output logic                mem_write_n_out,
  output logic                io_read_n_out,
  output logic                io_write_n_out,
  output logic                strobe_oe_n_out
);
  // ==========================================================================
  // Pin synchronisation
  logic [PIN_W-1:0] pins_s;
  logic             cs_n_s, ior_n_s, iow_n_s, hold_ack_s, eop_n_s;
  logic [3:0]       a_s;
  logic [7:0]       d_s;
  logic [NCH-1:0]   req_s;

  dma_pin_sync #(.WIDTH(PIN_W), .RESET_VAL(PIN_RESET)) u_sync (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .ce_in      (ce_in),
    .pins_in    ({cs_n_in, io_read_n_in, io_write_n_in, lower_addr_byte_in, data_in,
                  hold_ack_in, chan_req_in, end_of_process_n_in}),
    .pins_out   (pins_s)
  );
  assign {cs_n_s, ior_n_s, iow_n_s, a_s, d_s, hold_ack_s, req_s, eop_n_s} = pins_s;

  // ==========================================================================
  // State and registers
  state_type      state_reg, state_next;
  logic [7:0]     cmd_reg;
  logic [3:0]     mask_reg, sw_req_reg, tc_stat_reg;
  logic [7:0]     temp_reg, rd_data_reg, upper_latch_reg;
  logic           ff_reg, ior_d_reg, iow_d_reg, hold_req_reg, phase_reg;
  logic [1:0]     chan_reg, last_reg;
  mode_type       mode_reg [NCH];
  logic [15:0]    base_addr_reg [NCH];
  logic [15:0]    base_cnt_reg [NCH];
  logic [15:0]    channel_current_address_reg [NCH];
  logic [15:0]    cur_cnt_reg [NCH];

  // ==========================================================================
  // Program condition decode
  logic       prog, wr_pulse, rd_pulse, mclr, ff_access;
  logic [1:0] sel_ch, reg_ch;

  assign prog      = !cs_n_s && !hold_ack_s && (state_reg == ST_IDLE || state_reg == ST_WAIT_HOLD);
  assign wr_pulse  = prog && iow_d_reg && !iow_n_s;
  assign rd_pulse  = prog && ior_d_reg && !ior_n_s;
  assign mclr      = wr_pulse && (a_s == REG_MCLR_TEMP);
  assign ff_access = (wr_pulse || rd_pulse) && !a_s[CHAN_IDX];
  assign sel_ch    = d_s[SEL_MSB:0];
  assign reg_ch    = a_s[2:1];

  // ==========================================================================
  // Arbitration
  logic       m2m, active, m2m_act, ch_cascade;
  logic [3:0] pend;
  logic [1:0] grant;
  mode_type   cur_mode;

  function automatic logic [1:0] pick(input logic [3:0] p, input logic [1:0] base);
    logic [1:0] idx;
    pick = base;
    for (int i = NCH - 1; i >= 0; i--) begin
      idx = base + 2'(i);
      if (p[idx]) pick = idx;
    end
  endfunction : pick

  assign m2m      = cmd_reg[CMD_M2M];
  assign pend     = ((req_s & ~mask_reg) | sw_req_reg) & (m2m ? M2M_REQ_MASK : MASK_RESET);
  assign grant    = pick(pend, cmd_reg[CMD_ROTATE] ? last_reg + 2'h1 : 2'h0);
  assign cur_mode = mode_reg[chan_reg];
  assign m2m_act  = m2m && (chan_reg == 2'h0);
  assign active   = (state_reg == ST_ADDR_UPDATE) || (state_reg == ST_ADDR_CHANGE) ||
                    (state_reg == ST_READ_EXTEND) || (state_reg == ST_STROBE);
  assign ch_cascade = (cur_mode.mode == XM_CASCADE) && !m2m_act;

  // ==========================================================================
  // Transfer datapath
  logic [1:0]  addr_ch, cnt_ch;
  logic [15:0] addr_cur, addr_upd;
  logic        counting, tc_step, ext_eop, xfer_ok, done, eop_end, stop, hold_src;
  logic        f_in_ready, f_out_valid;
  logic [7:0]  f_out_data, next_upper;

  assign addr_ch  = m2m_act ? {1'b0, phase_reg} : chan_reg;
  assign cnt_ch   = m2m_act ? 2'h1 : chan_reg;
  assign addr_cur = channel_current_address_reg[addr_ch];
  assign addr_upd = mode_reg[addr_ch].dec ? addr_cur - ADDR_STEP : addr_cur + ADDR_STEP;
  assign hold_src = m2m_act && !phase_reg && cmd_reg[CMD_HOLD0];
  assign counting = !m2m_act || phase_reg;
  assign tc_step  = counting && (cur_cnt_reg[cnt_ch] == COUNT_ZERO);
  assign ext_eop  = !eop_n_s;
  assign xfer_ok  = !m2m_act || (phase_reg ? f_out_valid : f_in_ready);
  assign done     = (state_reg == ST_STROBE) && xfer_ok;
  assign eop_end  = tc_step || ext_eop;
  // Upper byte of the next transfer: the other copy channel, or this channel after its step.
  assign next_upper = m2m_act ? channel_current_address_reg[{1'b0, !phase_reg}][15:8]
                              : addr_upd[15:8];
  always_comb begin
    stop = eop_end;
    if (!m2m_act && cur_mode.mode == XM_SINGLE) stop = 1'b1;
    if (!m2m_act && cur_mode.mode == XM_DEMAND && !req_s[chan_reg]) stop = 1'b1;
  end

  dma_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .nrst_in       (nrst_in),
    .ce_in         (ce_in),
    .clear_in      (mclr),
    .in_valid_in   (done && m2m_act && !phase_reg),
    .in_ready_out  (f_in_ready),
    .in_data_in    (d_s),
    .out_valid_out (f_out_valid),
    .out_ready_in  (done && m2m_act && phase_reg),
    .out_data_out  (f_out_data)
  );

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (pend != '0 && !hold_ack_s && !cmd_reg[CMD_DISABLE]) state_next = ST_WAIT_HOLD;
      ST_WAIT_HOLD: begin
        if (hold_ack_s) state_next = ch_cascade ? ST_CASCADE : ST_ADDR_UPDATE;
      end
      ST_ADDR_UPDATE: state_next = ST_ADDR_CHANGE;
      ST_ADDR_CHANGE: begin
        state_next = cmd_reg[CMD_COMPRESS] ? ST_STROBE : ST_READ_EXTEND;
      end
      ST_READ_EXTEND: state_next = ST_STROBE;
      ST_STROBE: begin
        if (done) begin
          if (stop) begin
            state_next = ST_IDLE;
          end else if (next_upper != upper_latch_reg) begin
            state_next = ST_ADDR_UPDATE;
          end else begin
            state_next = ST_ADDR_CHANGE;
          end
        end
      end
      ST_CASCADE: if (!req_s[chan_reg]) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
    if (mclr) state_next = ST_IDLE;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg    <= ST_IDLE;
      hold_req_reg <= 1'b0;
      chan_reg     <= 2'h0;
      last_reg     <= 2'h3;
      phase_reg    <= 1'b0;
    end else if (ce_in) begin
      state_reg    <= state_next;
      hold_req_reg <= (state_next != ST_IDLE);
      if (state_reg == ST_IDLE) begin
        chan_reg  <= grant;
        phase_reg <= 1'b0;
      end
      if (done && m2m_act) phase_reg <= !phase_reg;
      if (state_next == ST_IDLE && state_reg != ST_IDLE && state_reg != ST_WAIT_HOLD) begin
        last_reg <= chan_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      upper_latch_reg <= 8'h00;
    end else if (ce_in && state_reg == ST_ADDR_UPDATE) begin
      upper_latch_reg <= addr_cur[15:8];
    end
  end

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_reg     <= CMD_RESET;
      mask_reg    <= MASK_RESET;
      sw_req_reg  <= 4'h0;
      tc_stat_reg <= 4'h0;
      ff_reg      <= 1'b0;
      temp_reg    <= 8'h00;
      rd_data_reg <= 8'h00;
      ior_d_reg   <= 1'b1;
      iow_d_reg   <= 1'b1;
    end else if (ce_in) begin
      ior_d_reg <= ior_n_s;
      iow_d_reg <= iow_n_s;
      if (ff_access) ff_reg <= !ff_reg;
      if (rd_pulse) begin
        case (a_s)
          REG_CMD_STAT:  rd_data_reg <= {req_s, tc_stat_reg};
          REG_MCLR_TEMP: rd_data_reg <= temp_reg;
          default: begin
            if (!a_s[CHAN_IDX] && !a_s[0]) begin
              rd_data_reg <= ff_reg ? channel_current_address_reg[reg_ch][15:8]
                                    : channel_current_address_reg[reg_ch][7:0];
            end else if (!a_s[CHAN_IDX]) begin
              rd_data_reg <= ff_reg ? cur_cnt_reg[reg_ch][15:8] : cur_cnt_reg[reg_ch][7:0];
            end else begin
              rd_data_reg <= 8'h00;
            end
          end
        endcase
      end
      if (wr_pulse) begin
        case (a_s)
          REG_CMD_STAT: cmd_reg <= d_s;
          REG_REQ:      sw_req_reg[sel_ch] <= d_s[SET_BIT];
          REG_MASK_BIT: mask_reg[sel_ch] <= d_s[SET_BIT];
          REG_MASK_ALL: mask_reg <= d_s[3:0];
          REG_CLR_MASK: mask_reg <= 4'h0;
          REG_CLR_FF:   ff_reg <= 1'b0;
          default: ;
        endcase
      end
      if (rd_pulse && a_s == REG_CMD_STAT) tc_stat_reg <= 4'h0;
      if (done && m2m_act && phase_reg) temp_reg <= f_out_data;
      if (done && stop) begin
        if (eop_end) begin
          tc_stat_reg[cnt_ch] <= 1'b1;
          sw_req_reg[chan_reg] <= 1'b0;
          if (!mode_reg[chan_reg].autoinit) mask_reg[chan_reg] <= 1'b1;
        end
      end
      if (mclr) begin
        cmd_reg     <= CMD_RESET;
        mask_reg    <= MASK_RESET;
        sw_req_reg  <= 4'h0;
        tc_stat_reg <= 4'h0;
        ff_reg      <= 1'b0;
        temp_reg    <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Channel address, count and mode registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NCH; i++) begin
        mode_reg[i]                    <= '0;
        base_addr_reg[i]               <= COUNT_ZERO;
        base_cnt_reg[i]                <= COUNT_ZERO;
        channel_current_address_reg[i] <= COUNT_ZERO;
        cur_cnt_reg[i]                 <= COUNT_ZERO;
      end
    end else if (ce_in) begin
      if (wr_pulse && a_s == REG_MODE) mode_reg[sel_ch] <= mode_type'(d_s[7:MODE_LSB]);
      if (wr_pulse && !a_s[CHAN_IDX]) begin
        if (!a_s[0]) begin
          if (ff_reg) begin
            base_addr_reg[reg_ch][15:8]               <= d_s;
            channel_current_address_reg[reg_ch][15:8] <= d_s;
          end else begin
            base_addr_reg[reg_ch][7:0]               <= d_s;
            channel_current_address_reg[reg_ch][7:0] <= d_s;
          end
        end else if (ff_reg) begin
          base_cnt_reg[reg_ch][15:8] <= d_s;
          cur_cnt_reg[reg_ch][15:8]  <= d_s;
        end else begin
          base_cnt_reg[reg_ch][7:0] <= d_s;
          cur_cnt_reg[reg_ch][7:0]  <= d_s;
        end
      end
      if (done) begin
        if (!hold_src) channel_current_address_reg[addr_ch] <= addr_upd;
        if (counting) cur_cnt_reg[cnt_ch] <= cur_cnt_reg[cnt_ch] - ADDR_STEP;
        if (stop && eop_end) begin
          for (int i = 0; i < NCH; i++) begin
            if ((i == int'(chan_reg) || i == int'(cnt_ch)) && mode_reg[i].autoinit) begin
              channel_current_address_reg[i] <= base_addr_reg[i];
              cur_cnt_reg[i]                 <= base_cnt_reg[i];
            end
          end
        end
      end
    end
  end

  // ==========================================================================
  // Outputs
  strobe_type stb;
  logic       drive_bus, rd_time;

  assign drive_bus = active && !ch_cascade;
  assign rd_time   = (state_reg == ST_READ_EXTEND) || (state_reg == ST_STROBE);
  always_comb begin
    stb = '0;
    if (m2m_act) begin
      stb.mem_rd = !phase_reg && rd_time;
      stb.mem_wr = phase_reg && (state_reg == ST_STROBE);
    end else if (drive_bus) begin
      case (cur_mode.kind)
        XT_WRITE: begin
          stb.io_rd  = rd_time;
          stb.mem_wr = (state_reg == ST_STROBE);
        end
        XT_READ: begin
          stb.mem_rd = rd_time;
          stb.io_wr  = (state_reg == ST_STROBE);
        end
        default: stb = '0;
      endcase
    end
  end

  assign mem_read_n_out    = !stb.mem_rd;
  assign mem_write_n_out   = !stb.mem_wr;
  assign io_read_n_out     = !stb.io_rd;
  assign io_write_n_out    = !stb.io_wr;
  assign strobe_oe_n_out   = !drive_bus;
  assign addr_oe_n_out     = !drive_bus;
  assign lower_addr_byte_out = addr_cur[7:0];
  assign upper_addr_strobe_out = (state_reg == ST_ADDR_UPDATE);
  assign upper_addr_enable_out = drive_bus;
  assign hold_req_out      = hold_req_reg;
  assign chan_ack_out      = cmd_reg[CMD_ACK_HIGH] ?
                             ((active && !m2m_act) || state_reg == ST_CASCADE ?
                              NCH'(1) << chan_reg : '0) :
                             ~((active && !m2m_act) || state_reg == ST_CASCADE ?
                              NCH'(1) << chan_reg : '0);
  assign end_of_process_n_out    = !(state_reg == ST_STROBE && tc_step);
  assign end_of_process_oe_n_out = !(state_reg == ST_STROBE && tc_step);
  assign data_out = (state_reg == ST_ADDR_UPDATE) ? addr_cur[15:8] :
                    (m2m_act && phase_reg) ? f_out_data : rd_data_reg;
  assign data_oe_n_out = !((prog && !ior_n_s) || (state_reg == ST_ADDR_UPDATE) ||
                           (m2m_act && phase_reg && active && !ch_cascade));
endmodule : dma_active
`default_nettype wire

// File: bench/dma_active_checker.sv
// Pin-relation checker of the DMA active-cycle block.
`timescale 1ns/10ps
`default_nettype none
module dma_active_checker (
  // Clock, reset and watched pins
  input wire logic       clk_sys_in, nrst_in, hold_req_out, upper_addr_strobe_out,
  input wire logic       upper_addr_enable_out, mem_read_n_out, mem_write_n_out,
  input wire logic       io_read_n_out, io_write_n_out, end_of_process_n_out,
  input wire logic       end_of_process_oe_n_out,
  input wire logic [3:0] chan_ack_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_wr; $rose(io_read_n_out) |-> !$past(mem_write_n_out); endproperty
  a_wr: assert property (p_wr) else $error("io read alone");
  property p_rd; !io_write_n_out |-> !mem_read_n_out; endproperty
  a_rd: assert property (p_rd) else $error("io write alone");
  property p_eop;
    !end_of_process_oe_n_out |-> !end_of_process_n_out && upper_addr_enable_out && hold_req_out;
  endproperty
  a_eop: assert property (p_eop) else $error("eop driven high");
  property p_eop_pulse; !end_of_process_oe_n_out |=> end_of_process_oe_n_out; endproperty
  a_eop_pulse: assert property (p_eop_pulse) else $error("eop pulse too long");
  property p_ads; upper_addr_strobe_out |-> upper_addr_enable_out; endproperty
  a_ads: assert property (p_ads) else $error("strobe without enable");
  property p_ads_one; upper_addr_strobe_out |=> !upper_addr_strobe_out; endproperty
  a_ads_one: assert property (p_ads_one) else $error("update state repeated");
  property p_start; $rose(upper_addr_enable_out) |-> hold_req_out; endproperty
  a_start: assert property (p_start) else $error("active without hold");
  property p_quiet;
    !upper_addr_enable_out |-> &{mem_read_n_out, mem_write_n_out, io_read_n_out, io_write_n_out};
  endproperty
  a_quiet: assert property (p_quiet) else $error("strobe while idle");
  property p_ack; !hold_req_out |-> chan_ack_out == 4'hF; endproperty
  a_ack: assert property (p_ack) else $error("ack without hold");
endmodule : dma_active_checker
bind dma_active dma_active_checker chk_u (.clk_sys_in, .nrst_in, .hold_req_out,
  .upper_addr_strobe_out, .upper_addr_enable_out, .mem_read_n_out, .mem_write_n_out,
  .io_read_n_out, .io_write_n_out, .end_of_process_n_out, .end_of_process_oe_n_out,
  .chan_ack_out);
`default_nettype wire

// File: bench/dma_far_model.sv
// Far-side model: processor hold handshake and requesting peripherals.
`timescale 1ns/10ps
`default_nettype none
module dma_far_model (
  // Clock, reset and pacing
  input  wire logic       clk_sys_in, nrst_in, slow_in,
  // Device side
  input  wire logic       hold_req_in,
  input  wire logic [3:0] chan_ack_in, want_in,
  output logic            hold_ack_out,
  output logic      [3:0] chan_req_out
);
  logic [1:0] wait_reg;
  logic [3:0] pend_reg;
  // Acknowledge follows one or three clocks after hold is seen and drops with it.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_reg     <= 2'h0;
      hold_ack_out <= 1'b0;
    end else if (!hold_req_in) begin
      wait_reg     <= 2'h0;
      hold_ack_out <= 1'b0;
    end else begin
      wait_reg     <= wait_reg + 2'h1;
      hold_ack_out <= hold_ack_out | (wait_reg >= (slow_in ? 2'h3 : 2'h1));
    end
  end
  // A request stays up until its active-low acknowledge appears.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) pend_reg <= 4'h0;
    else pend_reg <= (pend_reg | want_in) & chan_ack_in;
  end
  assign chan_req_out = pend_reg | want_in;
endmodule : dma_far_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench of the DMA active-cycle block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dma_pkg::*;
  logic clk_sys_in = 0, nrst_in = 0, cs_n_in = 1, io_read_n_in = 1, io_write_n_in = 1, slow = 0;
  logic [3:0] lower_addr_byte_in = 4'h0, want = 4'h0, chan_req_in, chan_ack_out;
  logic [7:0] data_in = 8'h00, data_out, q[$];
  logic hold_req_out, hold_ack_in, end_of_process_n_out, end_of_process_oe_n_out;
  logic data_oe_n_out, upper_addr_strobe_out, upper_addr_enable_out, mem_read_n_out;
  logic mem_write_n_out, io_read_n_out, io_write_n_out;
  logic [15:0] a;
  int err_count = 0, n_tests = 0, nhr = 0, seed = 32'hcbbd;
  wire end_of_process_n_in = end_of_process_oe_n_out | end_of_process_n_out;
  dma_active dut_u (.clk_sys_in, .nrst_in, .ce_in(1'b1), .cs_n_in, .io_read_n_in,
    .io_write_n_in, .lower_addr_byte_in, .data_in, .data_out, .data_oe_n_out,
    .hold_req_out, .hold_ack_in, .chan_req_in, .chan_ack_out, .end_of_process_n_in,
    .end_of_process_n_out, .end_of_process_oe_n_out, .lower_addr_byte_out(),
    .addr_oe_n_out(), .upper_addr_strobe_out, .upper_addr_enable_out, .mem_read_n_out,
    .mem_write_n_out, .io_read_n_out, .io_write_n_out, .strobe_oe_n_out());
  dma_far_model far_u (.clk_sys_in, .nrst_in, .slow_in(slow), .hold_req_in(hold_req_out),
    .chan_ack_in(chan_ack_out), .want_in(want), .hold_ack_out(hold_ack_in),
    .chan_req_out(chan_req_in));
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge hold_req_out) nhr++;
  always @(posedge data_oe_n_out)
    if (q.size() != 0) chk({8'h00, data_out}, {8'h00, q.pop_front()}, "read data");
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] seen, exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic rd, input logic [3:0] ad, input logic [7:0] d);
    lower_addr_byte_in = ad;
    data_in = d;
    cs_n_in = 0;
    if (rd) q.push_back(d);
    io_read_n_in = !rd;
    io_write_n_in = rd;
    step(5);
    {cs_n_in, io_read_n_in, io_write_n_in} = 3'h7;
    step(4);
  endtask : acc
  // Programs one channel, lets the far side request it, then reads back address and count.
  task automatic run(input logic [1:0] ch, input logic [7:0] md, cnt,
                     input logic keep, input logic [15:0] ea, ec);
    acc(0, REG_CLR_FF, 8'h00);
    acc(0, {1'b0, ch, 1'b0}, a[7:0]);
    acc(0, {1'b0, ch, 1'b0}, a[15:8]);
    acc(0, {1'b0, ch, 1'b1}, cnt);
    acc(0, {1'b0, ch, 1'b1}, 8'h00);
    acc(0, REG_MODE, md);
    want[ch] = 1;
    step(1);
    want[ch] = keep;
    @(negedge end_of_process_n_out);
    step(1);
    want = 4'h0;
    step(20);
    acc(0, REG_CLR_FF, 8'h5A);
    acc(1, {1'b0, ch, 1'b0}, ea[7:0]);
    acc(1, {1'b0, ch, 1'b0}, ea[15:8]);
    acc(1, {1'b0, ch, 1'b1}, ec[7:0]);
    acc(1, {1'b0, ch, 1'b1}, ec[15:8]);
  endtask : run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    step(5);
    nrst_in = 1;
    step(3);
    acc(0, REG_MCLR_TEMP, 8'h00);
    acc(0, REG_CLR_MASK, 8'h00);
    a = 16'($random(seed));
    run(2'd2, 8'h96, 8'h03, 1'b0, a, 16'h0003);
    acc(1, REG_CMD_STAT, 8'h04);
    chk(nhr[15:0], 16'd1, "hold rises");
    $display("test block autoinit done");
    a = 16'($random(seed));
    slow = 1;
    run(2'd1, 8'h69, 8'h01, 1'b1, a - 16'h0002, 16'hFFFF);
    acc(1, REG_CMD_STAT, 8'h02);
    chk(nhr[15:0], 16'd3, "hold rises");
    $display("test single decrement done");
    a = 16'($random(seed));
    acc(0, REG_CMD_STAT, 8'h08);
    run(2'd3, 8'h0B, 8'h02, 1'b1, a + 16'h0003, 16'hFFFF);
    acc(1, REG_CMD_STAT, 8'h08);
    chk(nhr[15:0], 16'd4, "hold rises");
    $display("test demand compressed done");
    report_and_stop();
  end
  initial begin
    step(30000);
    err_count++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
